// ===== alu_consts.vh
// constants for the accumulator load unit
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define ALU_OP_W 3
`define ALU_OP_LOAD_DOUBLE_MEM 3'h0
`define ALU_OP_LOAD_DOUBLE_CONST 3'h1
`define ALU_OP_LOAD_BIT_FIELD 3'h2
`define ALU_OP_LOAD_CONVERTED_ADDRESS 3'h3
`define ALU_OP_LOAD_INDEXED_WORD 3'h4
`define ALU_OP_STORE 3'h5
`define ALU_OP_END_SCAN 3'h6

// ---------------------------------------------------------------
// widths, limits and reset values
// ---------------------------------------------------------------
`define ALU_ACC_W 32
`define ALU_WORD_W 16
`define ALU_ADDR_W 16
`define ALU_CNT_W 6
`define ALU_CNT_MIN 6'h01
`define ALU_CNT_MAX 6'h20
`define ALU_STACK_DEPTH 8
`define ALU_OCT_DIGITS 6
`define ALU_ADDR_STEP 16'h0001
`define ALU_ACC_RST 32'h00000000
`define ALU_WORD_ZERO 16'h0000

`endif

// ===== alu_load_unit.v
// accumulator load unit: double, bit field, converted address, indexed
`timescale 1ns/1ps
`include "alu_consts.vh"

module alu_load_unit #(
	parameter STACK_DEPTH = `ALU_STACK_DEPTH
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire cmd_valid,
	input wire [`ALU_OP_W-1:0] cmd_op,
	input wire [`ALU_ADDR_W-1:0] cmd_addr,
	input wire [`ALU_ACC_W-1:0] cmd_const,
	input wire [`ALU_CNT_W-1:0] cmd_count,
	output reg cmd_ready,
	output reg wmem_rd_en,
	output reg [`ALU_ADDR_W-1:0] wmem_addr,
	input wire [`ALU_WORD_W-1:0] wmem_rd_data,
	output reg bmem_rd_en,
	output reg [`ALU_ADDR_W-1:0] bmem_addr,
	input wire bmem_rd_data,
	output reg [`ALU_ACC_W-1:0] acc,
	output reg [`ALU_ACC_W-1:0] stack_level1,
	output reg zero_result_flag,
	output reg done,
	output reg cmd_error
);

// ---------------------------------------------------------------
// states
// ---------------------------------------------------------------
localparam S_IDLE = 3'h0;
localparam S_WORD_LO = 3'h1;
localparam S_WORD_HI = 3'h2;
localparam S_BITS = 3'h3;
localparam S_INDEX = 3'h4;
localparam S_FINISH = 3'h5;

// ---------------------------------------------------------------
// octal operand helpers
// ---------------------------------------------------------------
// one octal digit per nibble, lowest digit in the lowest nibble
function [`ALU_WORD_W-1:0] alu_oct_to_bin;
	input [`ALU_ACC_W-1:0] d;
	integer i;
	reg [17:0] r;
	begin
		r = 18'h00000;
		for (i = 0; i < `ALU_OCT_DIGITS; i = i + 1) begin
			r[3*i +: 3] = d[4*i +: 3];
		end
		alu_oct_to_bin = r[15:0];
	end
endfunction

// every digit 0..7, no digit beyond the sixth, result fits 16 bits
function alu_oct_ok;
	input [`ALU_ACC_W-1:0] d;
	integer i;
	reg ok;
	begin
		ok = (d[31:24] == 8'h00) && (d[22:21] == 2'h0);
		for (i = 0; i < `ALU_OCT_DIGITS; i = i + 1) begin
			if (d[4*i+3]) begin
				ok = 1'b0;
			end
		end
		alu_oct_ok = ok;
	end
endfunction

// ---------------------------------------------------------------
// command decode
// ---------------------------------------------------------------
// loads are the only commands that complete a value into acc
function alu_is_load;
	input [`ALU_OP_W-1:0] op;
	begin
		alu_is_load = (op == `ALU_OP_LOAD_DOUBLE_MEM) ||
			(op == `ALU_OP_LOAD_DOUBLE_CONST) ||
			(op == `ALU_OP_LOAD_BIT_FIELD) ||
			(op == `ALU_OP_LOAD_CONVERTED_ADDRESS) ||
			(op == `ALU_OP_LOAD_INDEXED_WORD);
	end
endfunction

// bit field counts outside 1..32 are refused
function alu_count_ok;
	input [`ALU_CNT_W-1:0] n;
	begin
		alu_count_ok = (n >= `ALU_CNT_MIN) && (n <= `ALU_CNT_MAX);
	end
endfunction

// ---------------------------------------------------------------
// state and working registers
// ---------------------------------------------------------------
reg [2:0] state;
reg [`ALU_ACC_W-1:0] result;
reg [`ALU_ACC_W-1:0] gather;
reg [`ALU_CNT_W-1:0] bit_cnt;
reg [`ALU_CNT_W-1:0] bit_got;
reg push_pending;
reg [`ALU_ACC_W-1:0] stack [0:STACK_DEPTH-1];

wire accept;
wire op_is_load;
wire count_ok;
wire oct_ok;
wire params_ok;
wire do_push;
wire [`ALU_ACC_W-1:0] offset_src;
wire [`ALU_ADDR_W-1:0] index_addr;
wire [`ALU_ACC_W-1:0] next_gather;
wire bit_last;

// ---------------------------------------------------------------
// decode and push control
// ---------------------------------------------------------------
// commands are only taken while idle
assign accept = cmd_valid && cmd_ready && (state == S_IDLE);
assign op_is_load = alu_is_load(cmd_op);
assign count_ok = alu_count_ok(cmd_count);
assign oct_ok = alu_oct_ok(cmd_const);
assign params_ok = !((cmd_op == `ALU_OP_LOAD_BIT_FIELD) && !count_ok) &&
	!((cmd_op == `ALU_OP_LOAD_CONVERTED_ADDRESS) && !oct_ok);
// refused loads leave acc and stack untouched
assign do_push = accept && op_is_load && params_ok && push_pending;

// the prior acc becomes level one in the same cycle it is used
assign offset_src = push_pending ? acc : stack_level1;
// offset added as plain binary, no octal conversion
assign index_addr = cmd_addr + offset_src[`ALU_ADDR_W-1:0];

// ---------------------------------------------------------------
// bit gather
// ---------------------------------------------------------------
// each new bit lands one place above the one before it
assign next_gather = gather |
	({{(`ALU_ACC_W-1){1'b0}}, bmem_rd_data} << bit_got[4:0]);
assign bit_last = (bit_got == bit_cnt - `ALU_CNT_MIN);

// ---------------------------------------------------------------
// accumulator stack
// ---------------------------------------------------------------
integer k;
always @(posedge ref_clk) begin
	if (sys_rst) begin
		for (k = 0; k < STACK_DEPTH; k = k + 1) begin
			stack[k] <= `ALU_ACC_RST;
		end
		stack_level1 <= `ALU_ACC_RST;
	end else if (do_push) begin
		// deepest level is overwritten and lost
		for (k = 1; k < STACK_DEPTH; k = k + 1) begin
			stack[k] <= stack[k-1];
		end
		stack[0] <= acc;
		// port copy of level one, the offset source for indexed loads
		stack_level1 <= acc;
	end
end

// ---------------------------------------------------------------
// command sequencer
// ---------------------------------------------------------------
always @(posedge ref_clk) begin
	if (sys_rst) begin
		state <= S_IDLE;
		cmd_ready <= 1'b1;
		wmem_rd_en <= 1'b0;
		wmem_addr <= `ALU_WORD_ZERO;
		bmem_rd_en <= 1'b0;
		bmem_addr <= `ALU_WORD_ZERO;
		acc <= `ALU_ACC_RST;
		zero_result_flag <= 1'b0;
		done <= 1'b0;
		cmd_error <= 1'b0;
		result <= `ALU_ACC_RST;
		gather <= `ALU_ACC_RST;
		bit_cnt <= `ALU_CNT_MIN;
		bit_got <= 6'h00;
		push_pending <= 1'b0;
	end else begin
		done <= 1'b0;
		cmd_error <= 1'b0;
		case (state)
		S_IDLE: begin
			if (accept) begin
				if (op_is_load && !params_ok) begin
					cmd_error <= 1'b1;
				end else begin
					case (cmd_op)
					`ALU_OP_LOAD_DOUBLE_MEM: begin
						cmd_ready <= 1'b0;
						wmem_rd_en <= 1'b1;
						wmem_addr <= cmd_addr;
						state <= S_WORD_LO;
					end
					`ALU_OP_LOAD_DOUBLE_CONST: begin
						cmd_ready <= 1'b0;
						result <= cmd_const;
						state <= S_FINISH;
					end
					`ALU_OP_LOAD_BIT_FIELD: begin
						cmd_ready <= 1'b0;
						gather <= `ALU_ACC_RST;
						bit_cnt <= cmd_count;
						bit_got <= 6'h00;
						bmem_rd_en <= 1'b1;
						bmem_addr <= cmd_addr;
						state <= S_BITS;
					end
					`ALU_OP_LOAD_CONVERTED_ADDRESS: begin
						cmd_ready <= 1'b0;
						result <= {`ALU_WORD_ZERO,
							alu_oct_to_bin(cmd_const)};
						state <= S_FINISH;
					end
					`ALU_OP_LOAD_INDEXED_WORD: begin
						cmd_ready <= 1'b0;
						wmem_rd_en <= 1'b1;
						wmem_addr <= index_addr;
						state <= S_INDEX;
					end
					`ALU_OP_STORE: begin
						push_pending <= 1'b0;
						done <= 1'b1;
					end
					`ALU_OP_END_SCAN: begin
						acc <= `ALU_ACC_RST;
						push_pending <= 1'b0;
						done <= 1'b1;
					end
					default: begin
						cmd_error <= 1'b1;
					end
					endcase
				end
			end
		end
		S_WORD_LO: begin
			result[15:0] <= wmem_rd_data;
			wmem_addr <= wmem_addr + `ALU_ADDR_STEP;
			state <= S_WORD_HI;
		end
		S_WORD_HI: begin
			result[31:16] <= wmem_rd_data;
			wmem_rd_en <= 1'b0;
			state <= S_FINISH;
		end
		S_BITS: begin
			gather <= next_gather;
			if (bit_last) begin
				bmem_rd_en <= 1'b0;
				result <= next_gather;
				state <= S_FINISH;
			end else begin
				bmem_addr <= bmem_addr + `ALU_ADDR_STEP;
				bit_got <= bit_got + 6'h01;
			end
		end
		S_INDEX: begin
			result <= {`ALU_WORD_ZERO, wmem_rd_data};
			wmem_rd_en <= 1'b0;
			state <= S_FINISH;
		end
		S_FINISH: begin
			acc <= result;
			zero_result_flag <= (result == `ALU_ACC_RST);
			// every completed load arms a push for the next load
			push_pending <= 1'b1;
			done <= 1'b1;
			cmd_ready <= 1'b1;
			state <= S_IDLE;
		end
		default: begin
			// unused state codes fall back to idle
			state <= S_IDLE;
			cmd_ready <= 1'b1;
			wmem_rd_en <= 1'b0;
			bmem_rd_en <= 1'b0;
		end
		endcase
	end
end

endmodule

// ===== alu_load_props.sv
// property checker for the accumulator load unit
`timescale 1ns/1ps
module alu_load_props (
	input wire ref_clk,
	input wire sys_rst,
	input wire cmd_valid,
	input wire [2:0] cmd_op,
	input wire [15:0] cmd_addr,
	input wire [31:0] cmd_const,
	input wire [5:0] cmd_count,
	input wire cmd_ready,
	input wire wmem_rd_en,
	input wire [15:0] wmem_addr,
	input wire [31:0] acc,
	input wire [31:0] stack_level1,
	input wire zero_result_flag,
	input wire done,
	input wire cmd_error
);
	reg [2:0] op;
	reg [5:0] cnt;
	reg [17:0] oct;
	reg pend;
	wire take = cmd_valid && cmd_ready;
	wire ld = take && (cmd_op < 3'h2 || cmd_op == 3'h4);
	// push decision sees a load completing in the same cycle
	wire pnd = done ? op < 3'h5 : pend;
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			op <= 3'h7;
			cnt <= 6'h00;
			oct <= 18'h00000;
			pend <= 1'b0;
		end else begin
			if (take) begin
				op <= cmd_op;
				cnt <= cmd_count;
				// low three bits of nibble i give result bits 3i..3i+2
				oct <= {cmd_const[22:20], cmd_const[18:16], cmd_const[14:12],
					cmd_const[10:8], cmd_const[6:4], cmd_const[2:0]};
			end
			if (done)
				pend <= op < 3'h5;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_dbl;
		wmem_rd_en && wmem_addr == $past(cmd_addr)
		##1 wmem_addr == $past(cmd_addr, 2) + 16'h0001;
	endsequence
	sequence s_idx;
		wmem_rd_en && wmem_addr == $past(cmd_addr) + stack_level1[15:0];
	endsequence
	sequence s_load_end;
		done && acc[31:16] == 16'h0000;
	endsequence
	AST_DBL: assert property (take && cmd_op == 3'h0 |=> s_dbl ##2 done)
		else $error("double load address order wrong");
	AST_CONST: assert property (
		take && cmd_op == 3'h1 |-> ##2 done && acc == $past(cmd_const, 2))
		else $error("constant load wrong");
	AST_ZERO: assert property (
		done && op < 3'h5 |-> zero_result_flag == (acc == 32'h0))
		else $error("zero flag wrong");
	AST_PUSH: assert property (ld && pnd |=> stack_level1 == $past(acc))
		else $error("push missing");
	AST_NOPUSH: assert property (take && !pnd |=> $stable(stack_level1))
		else $error("unexpected push");
	AST_CNT: assert property (
		take && cmd_op == 3'h2 && (cmd_count == 6'h00 || cmd_count > 6'h20)
		|=> cmd_error && !done && $stable(acc))
		else $error("bad count not refused");
	AST_BITS: assert property (done && op == 3'h2 |-> (acc >> cnt) == 32'h0)
		else $error("bits above count set");
	AST_END: assert property (
		take && cmd_op == 3'h6 |=> done && acc == 32'h0)
		else $error("end of scan did not clear");
	AST_IDX: assert property (
		take && cmd_op == 3'h4 |=> s_idx ##2 s_load_end)
		else $error("indexed load wrong");
	AST_ADDR: assert property (
		done && op == 3'h3 |-> acc == {16'h0000, oct[15:0]})
		else $error("address load value wrong");
endmodule
bind alu_load_unit alu_load_props alu_load_props_inst (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
	.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_const(cmd_const),
	.cmd_count(cmd_count), .cmd_ready(cmd_ready), .wmem_rd_en(wmem_rd_en),
	.wmem_addr(wmem_addr), .acc(acc), .stack_level1(stack_level1),
	.zero_result_flag(zero_result_flag), .done(done), .cmd_error(cmd_error)
);

// ===== alu_mem_model.sv
// word and bit memory answering in the same cycle
`timescale 1ns/1ps
module alu_mem_model (
	input wire ref_clk,
	input wire wmem_rd_en,
	input wire [15:0] wmem_addr,
	output reg [15:0] wmem_rd_data,
	input wire bmem_rd_en,
	input wire [15:0] bmem_addr,
	output reg bmem_rd_data
);
	// unselected word reads see a pattern that changes every cycle, unselected bit reads a constant 0
	reg [15:0] junk = 16'h5A3C;
	always @(posedge ref_clk)
		junk <= ~junk ^ 16'h0101;
	always @* begin
		wmem_rd_data = wmem_rd_en ? wmem_addr ^ 16'hC35A : junk;
		bmem_rd_data = bmem_rd_en ? ^(bmem_addr & 16'h0049) : junk[0];
	end
endmodule

// ===== accumulator_load_unit_bench.sv
// self-checking bench for the accumulator load unit
`timescale 1ns/1ps
module accumulator_load_unit_bench;
	reg ref_clk = 0, sys_rst = 1, cmd_valid = 0;
	reg [2:0] cmd_op = 0;
	reg [15:0] cmd_addr = 0;
	reg [31:0] cmd_const = 0;
	reg [5:0] cmd_count = 0;
	wire cmd_ready, wmem_rd_en, bmem_rd_en, bmem_rd_data, done, cmd_error;
	wire zero_result_flag;
	wire [15:0] wmem_addr, bmem_addr, wmem_rd_data;
	wire [31:0] acc, stack_level1;
	integer bad_count = 0, n_compared = 0, seed = 30067, i;
	reg [31:0] stk [0:7];
	reg [31:0] ea = 0;
	reg ef = 0, pend = 0, er;
	reg [65:0] q [$];
	reg [65:0] e;
	alu_load_unit alu_load_unit_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_const(cmd_const), .cmd_count(cmd_count), .cmd_ready(cmd_ready),
		.wmem_rd_en(wmem_rd_en), .wmem_addr(wmem_addr),
		.wmem_rd_data(wmem_rd_data), .bmem_rd_en(bmem_rd_en),
		.bmem_addr(bmem_addr), .bmem_rd_data(bmem_rd_data), .acc(acc),
		.stack_level1(stack_level1), .zero_result_flag(zero_result_flag),
		.done(done), .cmd_error(cmd_error));
	alu_mem_model alu_mem_model_inst (.ref_clk(ref_clk),
		.wmem_rd_en(wmem_rd_en), .wmem_addr(wmem_addr),
		.wmem_rd_data(wmem_rd_data), .bmem_rd_en(bmem_rd_en),
		.bmem_addr(bmem_addr), .bmem_rd_data(bmem_rd_data));
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	task summarize;
		begin
			$display("compared %0d mismatches %0d", n_compared, bad_count);
			if (bad_count == 0 && n_compared > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task issue(input [2:0] op, input [15:0] a, input [31:0] k, input [5:0] n);
		reg [31:0] v;
		reg [15:0] w;
		reg [65:0] lost;
		integer j;
		begin
			er = 0;
			v = ea;
			case (op)
			0: v = {(a + 16'h1) ^ 16'hC35A, a ^ 16'hC35A};
			1: v = k;
			2: begin
				er = n == 0 || n > 32;
				v = 0;
				for (j = 0; j < n && j < 32; j = j + 1)
					v[j] = ^((a + j) & 16'h0049);
			end
			3: begin
				er = |k[31:21];
				v = 0;
				for (j = 0; j < 8; j = j + 1) begin
					er = er | k[4*j+3];
					v = v | (k[4*j +: 3] << 3*j);
				end
				v = v & 32'hFFFF;
			end
			4: begin
				w = (pend ? ea[15:0] : stk[0][15:0]) + a;
				v = w ^ 16'hC35A;
			end
			5: pend = 0;
			6: begin
				v = 0;
				pend = 0;
			end
			7: er = 1;
			endcase
			if (op < 5 && !er) begin
				if (pend) begin
					for (j = 7; j > 0; j = j - 1)
						stk[j] = stk[j-1];
					stk[0] = ea;
				end
				pend = 1;
				ef = v == 0;
			end
			if (!er)
				ea = v;
			q.push_back({er, ef, stk[0], ea});
			cmd_op = op;
			cmd_addr = a;
			cmd_const = k;
			cmd_count = n;
			cmd_valid = 1;
			@(negedge ref_clk);
			cmd_valid = 0;
			for (j = 0; j < 60 && done !== 1 && cmd_error !== 1; j = j + 1)
				@(negedge ref_clk);
			// no answer in time: count it and drop its note
			if (done !== 1 && cmd_error !== 1) begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED t=%0t got %h exp %h", $time,
					{done, cmd_error}, 2'h2);
				lost = q.pop_front();
			end
			// an idle edge keeps cmd_valid from toggling within one step
			@(negedge ref_clk);
		end
	endtask
	always @(negedge ref_clk) begin
		if (done === 1 || cmd_error === 1) begin
			e = q.pop_front();
			n_compared = n_compared + 1;
			if ({cmd_error, zero_result_flag, stack_level1, acc} !== e) begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED t=%0t got %h exp %h", $time,
					{cmd_error, zero_result_flag, stack_level1, acc}, e);
			end
		end
	end
	initial begin
		#1000000;
		bad_count = bad_count + 1;
		summarize;
	end
	initial begin
		for (i = 0; i < 8; i = i + 1)
			stk[i] = 0;
		repeat (4) @(negedge ref_clk);
		sys_rst = 0;
		issue(1, 0, 0, 0);
		issue(0, $random(seed), 0, 0);
		issue(5, 0, 0, 0);
		issue(1, 0, $random(seed), 0);
		issue(6, 0, 0, 0);
		$display("test basic loads done");
		for (i = 0; i < 10; i = i + 1)
			issue(1, 0, $random(seed), 0);
		$display("test stack done");
		for (i = 0; i < 34; i = i + 1)
			issue(2, $random(seed), 0, i);
		$display("test bit field done");
		issue(3, 0, 32'h00040400, 0);
		issue(3, 0, 32'h00000008, 0);
		issue(3, 0, 32'h00200000, 0);
		issue(7, 0, 0, 0);
		for (i = 0; i < 4; i = i + 1)
			issue(3, 0, $random(seed) & 32'h00177777, 0);
		$display("test address done");
		issue(3, 0, 32'h00000025, 0);
		issue(4, 16'h0308, 0, 0);
		issue(5, 0, 0, 0);
		issue(4, $random(seed), 0, 0);
		$display("test indexed done");
		for (i = 0; i < 60; i = i + 1)
			issue($random(seed), $random(seed), $random(seed), $random(seed));
		$display("test random done");
		summarize;
	end
endmodule
